// ---- shared/coc_pkg.sv ----
`default_nettype none
package coc_pkg;
  // ---------------------------------------------
  // Register offsets
  // ---------------------------------------------
  localparam logic [7:0] DELAY_LOW_ADDR = 8'h18;
  localparam logic [7:0] CONFIG_ADDR = 8'h19;
  localparam logic [7:0] FAULT_ADDR = 8'h81;
  localparam logic [7:0] STATUS_ADDR = 8'h82;
  localparam logic [7:0] SWITCH_ADDR = 8'h86;
  localparam logic [7:0] MODE_ADDR = 8'h87;
  // ---------------------------------------------
  // Reset values
  // ---------------------------------------------
  localparam logic [7:0] DELAY_LOW_RST = 8'ha0;
  localparam logic [6:0] CONFIG_RST = 7'h44;
  localparam logic [7:0] SWITCH_RST = 8'h03;
  localparam logic [7:0] MODE_RST = 8'h00;
  // ---------------------------------------------
  // Field positions
  // ---------------------------------------------
  localparam int THR_LSB = 4;
  localparam int UNIT_LSB = 2;
  localparam int FAULT_BIT = 1;
  localparam int PRESENT_BIT = 1;
  localparam int CLR_ERR_BIT = 5;
  localparam int MON_EN_BIT = 4;
  localparam int CHG_SW_BIT = 1;
  localparam int DSG_SW_BIT = 0;
  localparam int EXT_CTRL_BIT = 6;
  localparam int OVERRIDE_BIT = 3;
  // ---------------------------------------------
  // Delay units
  // ---------------------------------------------
  localparam logic [1:0] UNIT_US = 2'h0;
  localparam logic [1:0] UNIT_MS = 2'h1;
  localparam logic [1:0] UNIT_S = 2'h2;
  localparam logic [1:0] UNIT_MIN = 2'h3;
  // ---------------------------------------------
  // Timing
  // ---------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS = 1000;
  localparam int US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int US_PER_MS = 1000;
  localparam int MS_PER_S = 1000;
  localparam int S_PER_MIN = 60;
  localparam logic [9:0] SETTLE_S = 10'h003;
  localparam logic [9:0] MON_PERIOD_MS = 10'h100;
  localparam logic [1:0] ABSENT_NEEDED = 2'h2;
endpackage
`default_nettype wire

// ---- hdl/time_base.sv ----
`timescale 1ns/100ps
`default_nettype none
module time_base #(
  parameter int US_CYCLES = coc_pkg::US_CYCLES,
  parameter int US_PER_MS = coc_pkg::US_PER_MS,
  parameter int MS_PER_S = coc_pkg::MS_PER_S,
  parameter int S_PER_MIN = coc_pkg::S_PER_MIN
) (
  input wire logic sys_clk,
  input wire logic rst,
  output logic us_tick,
  output logic ms_tick,
  output logic s_tick,
  output logic min_tick
);
  logic [15:0] cyc;
  logic [15:0] us;
  logic [15:0] ms;
  logic [15:0] sec;
  wire cyc_end = (cyc == 16'(US_CYCLES - 1));
  wire us_end = cyc_end && (us == 16'(US_PER_MS - 1));
  wire ms_end = us_end && (ms == 16'(MS_PER_S - 1));
  wire s_end = ms_end && (sec == 16'(S_PER_MIN - 1));

  // Chained dividers keep each counter small
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cyc <= 16'h0000;
      us <= 16'h0000;
      ms <= 16'h0000;
      sec <= 16'h0000;
    end else begin
      cyc <= cyc_end ? 16'h0000 : cyc + 16'h0001;
      if (cyc_end)
        us <= us_end ? 16'h0000 : us + 16'h0001;
      if (us_end)
        ms <= ms_end ? 16'h0000 : ms + 16'h0001;
      if (ms_end)
        sec <= s_end ? 16'h0000 : sec + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      us_tick <= 1'b0;
      ms_tick <= 1'b0;
      s_tick <= 1'b0;
      min_tick <= 1'b0;
    end else begin
      us_tick <= cyc_end;
      ms_tick <= us_end;
      s_tick <= ms_end;
      min_tick <= s_end;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/charge_overcurrent_protect.sv ----
`timescale 1ns/100ps
`default_nettype none
module charge_overcurrent_protect #(
  parameter int US_CYCLES = coc_pkg::US_CYCLES,
  parameter int US_PER_MS = coc_pkg::US_PER_MS,
  parameter int MS_PER_S = coc_pkg::MS_PER_S,
  parameter int S_PER_MIN = coc_pkg::S_PER_MIN
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] sense_mv,
  input wire logic charger_monitor_pin,
  input wire logic other_faults,
  input wire logic [3:0] charger_detect_pulse_width,
  output logic charge_overcurrent_fault_flag,
  output logic charger_present_flag,
  output logic charge_switch_on,
  output logic discharge_switch_on,
  output logic charger_monitor_sink
);
  typedef enum {IDLE, SETTLE, PULSE, GAP} rec_state_e;

  // ---------------------------------------------
  // Decoders
  // ---------------------------------------------
  function automatic logic [7:0] thr_mv(input logic [2:0] code);
    case (code)
      3'h0: thr_mv = 8'h01;
      3'h1: thr_mv = 8'h02;
      3'h2: thr_mv = 8'h04;
      3'h3: thr_mv = 8'h06;
      3'h4: thr_mv = 8'h08;
      3'h5: thr_mv = 8'h0c;
      3'h6: thr_mv = 8'h10;
      default: thr_mv = 8'h18;
    endcase
  endfunction

  // ---------------------------------------------
  // State
  // ---------------------------------------------
  logic [7:0] delay_low;
  logic [6:0] config_bits;
  logic mon_en;
  logic ext_ctrl;
  logic override;
  logic mon_en_q;
  logic pin_s1, pin_s2, pin_s3;
  logic pin_level;
  logic [10:0] dly_cnt;
  logic [9:0] cnt;
  logic [1:0] absent_cnt;
  rec_state_e state;
  rec_state_e next_state;
  logic us_tick, ms_tick, s_tick, min_tick;

  time_base #(
    .US_CYCLES(US_CYCLES),
    .US_PER_MS(US_PER_MS),
    .MS_PER_S(MS_PER_S),
    .S_PER_MIN(S_PER_MIN)
  ) u_time_base (
    .sys_clk(sys_clk),
    .rst(rst),
    .us_tick(us_tick),
    .ms_tick(ms_tick),
    .s_tick(s_tick),
    .min_tick(min_tick)
  );

  // ---------------------------------------------
  // Register decode
  // ---------------------------------------------
  wire wr_low = reg_wr && (reg_addr == coc_pkg::DELAY_LOW_ADDR);
  wire wr_cfg = reg_wr && (reg_addr == coc_pkg::CONFIG_ADDR);
  wire wr_sw = reg_wr && (reg_addr == coc_pkg::SWITCH_ADDR);
  wire wr_mode = reg_wr && (reg_addr == coc_pkg::MODE_ADDR);
  wire clr_req = wr_sw && reg_wdata[coc_pkg::CLR_ERR_BIT];

  wire [2:0] thr_code = config_bits[coc_pkg::THR_LSB +: 3];
  wire [1:0] unit = config_bits[coc_pkg::UNIT_LSB +: 2];
  wire [9:0] delay_count = {config_bits[1:0], delay_low};

  // ---------------------------------------------
  // Detection
  // ---------------------------------------------
  wire above = sense_mv > thr_mv(thr_code);
  wire unit_tick = (unit == coc_pkg::UNIT_US) ? us_tick :
                   (unit == coc_pkg::UNIT_MS) ? ms_tick :
                   (unit == coc_pkg::UNIT_S) ? s_tick : min_tick;
  // Strictly greater: the delay must be exceeded, not just reached
  wire over_time = dly_cnt > {1'b0, delay_count};
  wire trip = above && over_time && !charge_overcurrent_fault_flag;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      dly_cnt <= 11'h000;
    else if (!above || charge_overcurrent_fault_flag)
      dly_cnt <= 11'h000;
    else if (unit_tick && !over_time)
      dly_cnt <= dly_cnt + 11'h001;
  end

  // ---------------------------------------------
  // Charger monitor pin synchroniser
  // ---------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
      pin_level <= 1'b0;
    end else begin
      pin_s1 <= charger_monitor_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3)
        pin_level <= pin_s3;
    end
  end

  // ---------------------------------------------
  // Recovery sequencer
  // ---------------------------------------------
  wire seq_run = charge_overcurrent_fault_flag && !override;
  wire [9:0] pw = {6'h00, charger_detect_pulse_width};
  wire pulse_end = (state == PULSE) && ms_tick &&
                   (cnt + 10'h001 >= pw);
  wire host_sample = override && mon_en_q && !mon_en;
  wire sample = pulse_end || host_sample;
  // Another fault restarts the count, so two clean samples are needed
  wire absent_now = sample && !pin_level && !other_faults;
  wire recover = pulse_end && !pin_level && !other_faults &&
                 (absent_cnt == coc_pkg::ABSENT_NEEDED - 2'h1);
  wire next_sink = override ? mon_en : (next_state == PULSE);

  always_comb begin
    next_state = state;
    case (state)
      IDLE:
        if (seq_run)
          next_state = SETTLE;
      SETTLE:
        if (s_tick && cnt == coc_pkg::SETTLE_S - 10'h001)
          next_state = PULSE;
      PULSE:
        if (pulse_end)
          next_state = GAP;
      GAP:
        if (ms_tick && cnt == coc_pkg::MON_PERIOD_MS - 10'h001)
          next_state = PULSE;
      default:
        next_state = IDLE;
    endcase
    if (!seq_run || recover)
      next_state = IDLE;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      state <= IDLE;
    else
      state <= next_state;
  end

  // One counter: seconds while settling, ms across a period
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      cnt <= 10'h000;
    else if (next_state != state && next_state != GAP)
      cnt <= 10'h000;
    else if ((state == SETTLE && s_tick) ||
             (state != SETTLE && ms_tick))
      cnt <= cnt + 10'h001;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      absent_cnt <= 2'h0;
    else if (!charge_overcurrent_fault_flag || !sample)
      absent_cnt <= charge_overcurrent_fault_flag ? absent_cnt : 2'h0;
    else if (!absent_now)
      absent_cnt <= 2'h0;
    else if (absent_cnt != coc_pkg::ABSENT_NEEDED)
      absent_cnt <= absent_cnt + 2'h1;
  end

  // ---------------------------------------------
  // Flags and switches
  // ---------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      charge_overcurrent_fault_flag <= 1'b0;
      charger_present_flag <= 1'b0;
      charger_monitor_sink <= 1'b0;
    end else begin
      charger_monitor_sink <= next_sink;
      // Set wins over any clear in the same cycle
      if (trip)
        charge_overcurrent_fault_flag <= 1'b1;
      else if (recover || (override && clr_req))
        charge_overcurrent_fault_flag <= 1'b0;
      if (trip)
        charger_present_flag <= 1'b1;
      else if (sample)
        charger_present_flag <= pin_level;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      charge_switch_on <= coc_pkg::SWITCH_RST[coc_pkg::CHG_SW_BIT];
      discharge_switch_on <= coc_pkg::SWITCH_RST[coc_pkg::DSG_SW_BIT];
    end else if (trip && !ext_ctrl) begin
      charge_switch_on <= 1'b0;
      discharge_switch_on <= 1'b0;
    end else if (recover && !ext_ctrl) begin
      charge_switch_on <= 1'b1;
      discharge_switch_on <= 1'b1;
    end else if (wr_sw) begin
      charge_switch_on <= reg_wdata[coc_pkg::CHG_SW_BIT];
      discharge_switch_on <= reg_wdata[coc_pkg::DSG_SW_BIT];
    end
  end

  // ---------------------------------------------
  // Configuration registers
  // ---------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      delay_low <= coc_pkg::DELAY_LOW_RST;
      config_bits <= coc_pkg::CONFIG_RST;
      mon_en <= coc_pkg::SWITCH_RST[coc_pkg::MON_EN_BIT];
      ext_ctrl <= coc_pkg::MODE_RST[coc_pkg::EXT_CTRL_BIT];
      override <= coc_pkg::MODE_RST[coc_pkg::OVERRIDE_BIT];
      mon_en_q <= 1'b0;
    end else begin
      mon_en_q <= mon_en;
      if (wr_low)
        delay_low <= reg_wdata;
      // Reserved top bit is not stored
      if (wr_cfg)
        config_bits <= reg_wdata[6:0];
      if (wr_sw)
        mon_en <= reg_wdata[coc_pkg::MON_EN_BIT];
      if (wr_mode) begin
        ext_ctrl <= reg_wdata[coc_pkg::EXT_CTRL_BIT];
        override <= reg_wdata[coc_pkg::OVERRIDE_BIT];
      end
    end
  end

  wire [7:0] sw_rd = ({7'h00, mon_en} << coc_pkg::MON_EN_BIT) |
    ({7'h00, charge_switch_on} << coc_pkg::CHG_SW_BIT) |
    ({7'h00, discharge_switch_on} << coc_pkg::DSG_SW_BIT);
  wire [7:0] mode_rd = ({7'h00, ext_ctrl} << coc_pkg::EXT_CTRL_BIT) |
    ({7'h00, override} << coc_pkg::OVERRIDE_BIT);
  wire [7:0] flt_rd = {7'h00, charge_overcurrent_fault_flag}
    << coc_pkg::FAULT_BIT;
  wire [7:0] st_rd = {7'h00, charger_present_flag}
    << coc_pkg::PRESENT_BIT;
  wire [7:0] rd_mux =
    (reg_addr == coc_pkg::DELAY_LOW_ADDR) ? delay_low :
    (reg_addr == coc_pkg::CONFIG_ADDR) ? {1'b0, config_bits} :
    (reg_addr == coc_pkg::FAULT_ADDR) ? flt_rd :
    (reg_addr == coc_pkg::STATUS_ADDR) ? st_rd :
    (reg_addr == coc_pkg::SWITCH_ADDR) ? sw_rd :
    (reg_addr == coc_pkg::MODE_ADDR) ? mode_rd : 8'h00;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_mux;
  end

  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_trip_sets_flags: assert property (
    trip |=> charge_overcurrent_fault_flag && charger_present_flag)
    else $error("trip did not set both flags");
  a_fault_needs_above: assert property (
    $rose(charge_overcurrent_fault_flag) |->
      $past(above) && $past(dly_cnt) > {1'b0, $past(delay_count)})
    else $error("fault raised before delay exceeded");
  a_auto_switch_off: assert property (
    trip && !ext_ctrl |=> !charge_switch_on && !discharge_switch_on)
    else $error("switches left on after fault");
  a_below_restarts: assert property (
    !above |=> dly_cnt == 11'h000)
    else $error("delay timer not restarted");
  a_thr_default: assert property (
    $fell(rst) |-> thr_mv(thr_code) == 8'h08 && unit == 2'h1)
    else $error("wrong default threshold or unit");
  a_default_delay: assert property (
    $fell(rst) |-> delay_count == 10'h0a0)
    else $error("default delay count is not 160");
  a_sample_follows: assert property (
    sample && !trip |=> charger_present_flag == $past(pin_level))
    else $error("charger flag does not follow sample");
  a_recover_restores: assert property (
    recover && !ext_ctrl |=> charge_switch_on && discharge_switch_on
      && !charge_overcurrent_fault_flag)
    else $error("recovery did not restore switches");
  a_recover_two: assert property (
    recover |-> absent_cnt == 2'h1 && !other_faults)
    else $error("recovered without two absent samples");
  a_host_clear: assert property (
    override && clr_req && !trip |=> !charge_overcurrent_fault_flag)
    else $error("clear bit ignored under override");
  a_override_sink: assert property (
    override && $past(override) |-> charger_monitor_sink == $past(mon_en))
    else $error("sink does not follow host pulse");
  a_pulse_gap: assert property (
    state == GAP && next_state == PULSE |-> ms_tick && cnt == 10'h0ff)
    else $error("pulse period is not 256 ms");

  c_trip: cover property (trip);
  c_auto_recover: cover property (recover && !ext_ctrl);
  c_host_clear: cover property (override && clr_req);
endmodule
`default_nettype wire

// ---- tb/charger_node.sv ----
`timescale 1ns/100ps
`default_nettype none
module charger_node (
  input wire logic sys_clk,
  input wire logic charger_monitor_sink,
  input wire logic connected,
  output logic charger_monitor_pin
);
  // With no charger and no sink the node floats, so the comparator wanders
  logic wander = 1'b0;
  logic [2:0] settle = 3'h0;
  logic idle;
  always @(posedge sys_clk) begin
    wander <= ~wander;
    if (charger_monitor_sink) begin
      settle <= 3'h4;
    end else if (settle != 3'h0) begin
      settle <= settle - 3'h1;
    end
  end
  assign idle = (settle == 3'h0) & ~charger_monitor_sink;
  assign charger_monitor_pin = connected | (idle & wander);
endmodule
`default_nettype wire

// ---- tb/charge_overcurrent_protect_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module charge_overcurrent_protect_tb;
  localparam int P_US = 2;
  localparam int P_MS = 4;
  localparam int P_S = 4;
  localparam int P_MIN = 3;
  localparam int LIMIT = 40000;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] sense_mv = 8'h00;
  logic other_faults = 1'b0;
  logic connected = 1'b1;
  logic [3:0] pulse_w = 4'h3;
  logic [7:0] reg_rdata;
  logic fault, present, chg_on, dsg_on, sink, pin;
  int seed = 32'h83e3;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  int tlo;
  int thi;
  time t0, tr, ts;
  int tq[$];
  logic [7:0] rq[$];
  int thr[8] = '{1, 2, 4, 6, 8, 12, 16, 24};
  int ut[4] = '{P_US, P_US*P_MS, P_US*P_MS*P_S, P_US*P_MS*P_S*P_MIN};
  logic [7:0] ra[7] = '{8'h18, 8'h19, 8'h81, 8'h82, 8'h86, 8'h87, 8'h33};
  logic [7:0] rv[7] = '{8'ha0, 8'h44, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00};

  always #5 sys_clk = ~sys_clk;

  charge_overcurrent_protect #(.US_CYCLES(P_US), .US_PER_MS(P_MS),
    .MS_PER_S(P_S), .S_PER_MIN(P_MIN)) u_charge_overcurrent_protect (
    .sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sense_mv(sense_mv), .charger_monitor_pin(pin),
    .other_faults(other_faults), .charger_detect_pulse_width(pulse_w),
    .charge_overcurrent_fault_flag(fault), .charger_present_flag(present),
    .charge_switch_on(chg_on), .discharge_switch_on(dsg_on),
    .charger_monitor_sink(sink));

  charger_node u_charger_node (.sys_clk(sys_clk),
    .charger_monitor_sink(sink), .connected(connected),
    .charger_monitor_pin(pin));

  // ---------------------------------------------
  // Compare and report
  // ---------------------------------------------
  task automatic cmp8(input string n, input logic [7:0] e,
                      input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp1(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic cmp_rng(input string n, input int lo, input int hi,
                         input int g);
    total_checks++;
    if (g < lo || g > hi) begin
      miscompares++;
      $display("mismatch %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------
  // Result watchers
  // ---------------------------------------------
  always @(posedge sys_clk) begin
    if (reg_rd === 1'b1) begin
      @(negedge sys_clk);
      cmp8($sformatf("reg %h", reg_addr), rq.pop_front(),
           reg_rdata);
    end
  end
  always @(posedge fault) begin
    if (tq.size() < 2) begin
      cmp_rng("trip", 0, 0, -1);
    end else begin
      // Pop in order: argument evaluation order is not fixed
      tlo = tq.pop_front();
      thi = tq.pop_front();
      cmp_rng("trip", tlo, thi, int'(($time - t0) / 10));
    end
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      miscompares++;
      print_verdict;
    end
  end

  // ---------------------------------------------
  // Drivers
  // ---------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    rq.push_back(e);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    reg_rd = 1'b0;
  endtask
  task automatic wsink(input logic lv);
    for (int i = 0; i < 2200 && sink !== lv; i++) @(negedge sys_clk);
  endtask
  task automatic pulse;
    wsink(1'b1);
    wsink(1'b0);
    repeat (6) @(negedge sys_clk);
  endtask
  // Quiet spell at or below threshold, optional early drop, then trip
  task automatic trip(input int c, input int cnt, input int u,
                      input bit gl, input bit w, input logic sw);
    int t;
    t = ut[u];
    if (w) begin
      wr(8'h18, cnt[7:0]);
      wr(8'h19, {1'b0, c[2:0], u[1:0], cnt[9:8]});
    end
    repeat ((cnt + 2) * t) begin
      sense_mv = 8'({$random(seed)} % (thr[c] + 1));
      @(negedge sys_clk);
    end
    if (gl) begin
      sense_mv = 8'(thr[c] + 1);
      repeat (cnt * t - 4) @(negedge sys_clk);
      sense_mv = 8'(thr[c]);
      @(negedge sys_clk);
    end
    sense_mv = 8'(thr[c] + 1 + {$random(seed)} % 8);
    t0 = $time;
    tq.push_back(cnt * t);
    tq.push_back((cnt + 1) * t + 3);
    for (int i = 0; i < (cnt + 1) * t + 10 && fault !== 1'b1; i++) begin
      @(negedge sys_clk);
    end
    sense_mv = 8'h00;
    cmp1("fault", 1'b1, fault);
    cmp1("present", 1'b1, present);
    cmp1("chg_on", sw, chg_on);
    cmp1("dsg_on", sw, dsg_on);
  endtask
  // Host-side recovery under override
  task automatic hclear;
    wr(8'h86, 8'h10);
    @(negedge sys_clk);
    cmp1("sink", 1'b1, sink);
    wr(8'h86, 8'h00);
    repeat (2) @(negedge sys_clk);
    rd(8'h82, 8'h00);
    wr(8'h86, 8'h20);
    rd(8'h81, 8'h00);
    wr(8'h86, 8'h03);
    rd(8'h86, 8'h03);
  endtask

  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    for (int k = 0; k < 7; k++) rd(ra[k], rv[k]);
    wr(8'h19, 8'hff);
    rd(8'h19, 8'h7f);
    wr(8'h19, 8'h44);
    wr(8'h81, 8'hff);
    rd(8'h81, 8'h00);
    trip(4, 160, 1, 1'b0, 1'b0, 1'b0);
    tr = $time;
    wsink(1'b1);
    cmp_rng("settle", 2*ut[2], 3*ut[2]+2*ut[1], int'(($time-tr)/10));
    ts = $time;
    wsink(1'b0);
    cmp_rng("width", 2*ut[1], 3*ut[1]+2, int'(($time-ts)/10));
    repeat (6) @(negedge sys_clk);
    cmp1("present", 1'b1, present);
    connected = 1'b0;
    other_faults = 1'b1;
    wsink(1'b1);
    cmp_rng("period", 255*ut[1], 257*ut[1], int'(($time-ts)/10));
    wsink(1'b0);
    repeat (6) @(negedge sys_clk);
    pulse;
    cmp1("present", 1'b0, present);
    cmp1("fault", 1'b1, fault);
    other_faults = 1'b0;
    pulse;
    pulse;
    cmp1("fault", 1'b0, fault);
    cmp1("chg_on", 1'b1, chg_on);
    cmp1("dsg_on", 1'b1, dsg_on);
    wr(8'h87, 8'h08);
    for (int u = 0; u < 4; u++) begin
      trip(4, 2, u, 1'b0, 1'b1, 1'b0);
      hclear;
    end
    for (int c = 0; c < 8; c++) begin
      trip(c, 3, 0, 1'b0, 1'b1, 1'b0);
      hclear;
    end
    trip(2, 5, 0, 1'b1, 1'b1, 1'b0);
    hclear;
    wr(8'h87, 8'h48);
    trip(4, 2, 0, 1'b0, 1'b1, 1'b1);
    wr(8'h86, 8'h00);
    @(negedge sys_clk);
    cmp1("chg_on", 1'b0, chg_on);
    hclear;
    print_verdict;
  end
endmodule
`default_nettype wire
